// ===== hw/cfrfh_crc.sv
// Purpose: one-byte step of an MSB-first CRC, no reflection, no final xor
// Assumes: caller holds the running value in its own register
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cfrfh_crc #(
    parameter int W = 16,
    parameter logic [W-1:0] POLY = {W{1'b0}}
) (
    input wire logic [W-1:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [W-1:0] crc_out
);
    logic [W-1:0] step [0:8];

    assign step[0] = crc_in;
    for (genvar i = 0; i < 8; i++) begin : g_bit
        logic fb;
        assign fb = step[i][W-1] ^ data_in[7-i];
        assign step[i+1] = {step[i][W-2:0], 1'b0} ^ (fb ? POLY : {W{1'b0}});
    end
    assign crc_out = step[8];
endmodule
`default_nettype wire

// ===== hw/cfrfh_frame_handler.sv
// Purpose: receive a request header and payload, check it, send the response header
// Assumes: byte streams from logic on sys_clk; payload sink never stalls
// Notes: a bad header checksum skips the payload, since its length is untrusted
`timescale 1ns/1ps
`default_nettype none
module cfrfh_frame_handler
    import cfrfh_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic pl_valid,
    output logic [7:0] pl_data,
    output logic req_valid,
    output logic [7:0] req_cmd,
    output logic [31:0] req_len,
    output logic frame_done,
    output logic [7:0] frame_status
);
    cfrfh_regs_s state_r;
    cfrfh_regs_s state_nxt;
    logic rx_fire;
    logic tx_fire;
    logic [5:0] nidx;
    logic [7:0] tx_next;
    logic [15:0] crc16_rx;
    logic [15:0] crc16_tx;
    logic [31:0] crc32_rx;
    logic cmd_known;
    logic hdr_crc_ok;
    logic go_rsp;

    function automatic logic [7:0] rsp_byte(input logic [5:0] i, input cfrfh_regs_s r);
        logic [7:0] b;
        case (i)
            OFS_SYNC_HI: b = SYNC_HI;
            OFS_SYNC_LO: b = SYNC_LO;
            OFS_VER: b = PROTO_REV;
            OFS_CMD: b = r.cmd;
            OFS_SUB: b = r.sub;
            OFS_STAT: b = r.status;
            OFS_FLAGS_HI: b = r.flags[15:8];
            OFS_FLAGS_LO: b = r.flags[7:0];
            OFS_HCRC_HI: b = r.tcrc[15:8];
            HDR_LAST: b = r.tcrc[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic logic [7:0] pl_check(input logic [31:0] crc, input cfrfh_regs_s r);
        logic [7:0] s;
        s = r.status;
        if (s == STAT_OK && !r.flags[FLAG_NO_PCRC] && crc != r.pcrc) begin
            s = STAT_PL_CRC;
        end
        return s;
    endfunction

    assign rx_fire = rx_valid && state_r.rx_ready;
    assign tx_fire = state_r.tx_valid && tx_ready;
    assign nidx = state_r.idx + 6'h01;
    assign tx_next = rsp_byte(nidx, state_r);
    assign hdr_crc_ok = ({state_r.hcrc_hi, rx_data} == state_r.crc16);
    // Sub-command plays no part in accepting a command
    assign cmd_known = (state_r.cmd == CMD_RD_DEPTH) || (state_r.cmd == CMD_RD_COLOUR)
        || (state_r.cmd == CMD_RD_EXTR) || (state_r.cmd == CMD_FL_BOOT)
        || (state_r.cmd == CMD_FL_APP);

    cfrfh_crc #(.W(16), .POLY(CRC16_POLY)) u_crc_rx16 (
        .crc_in(state_r.crc16),
        .data_in(rx_data),
        .crc_out(crc16_rx)
    );

    cfrfh_crc #(.W(16), .POLY(CRC16_POLY)) u_crc_tx16 (
        .crc_in(state_r.tcrc),
        .data_in(tx_next),
        .crc_out(crc16_tx)
    );

    cfrfh_crc #(.W(32), .POLY(CRC32_POLY)) u_crc_rx32 (
        .crc_in(state_r.crc32),
        .data_in(rx_data),
        .crc_out(crc32_rx)
    );

    always_comb begin
        state_nxt = state_r;
        state_nxt.pl_valid = 1'b0;
        state_nxt.req_valid = 1'b0;
        state_nxt.done = 1'b0;
        go_rsp = 1'b0;
        case (state_r.st)
            S_HDR: begin
                if (rx_fire) begin
                    state_nxt.idx = nidx;
                    if (state_r.idx == OFS_SYNC_HI) begin
                        state_nxt.crc16 = CRC16_INIT;
                        if (rx_data != SYNC_HI) begin
                            state_nxt.idx = OFS_SYNC_HI;
                        end
                    end
                    if (state_r.idx == OFS_SYNC_LO && rx_data != SYNC_LO) begin
                        // A repeated first sync byte may itself open the header
                        state_nxt.idx = (rx_data == SYNC_HI) ? OFS_SYNC_LO : OFS_SYNC_HI;
                    end
                    if (state_r.idx >= CRC_FIRST && state_r.idx <= CRC_LAST) begin
                        state_nxt.crc16 = crc16_rx;
                    end
                    if (state_r.idx == OFS_VER) begin
                        state_nxt.ver_bad = (rx_data != PROTO_REV);
                    end
                    if (state_r.idx == OFS_CMD) begin
                        state_nxt.cmd = rx_data;
                    end
                    if (state_r.idx == OFS_SUB) begin
                        state_nxt.sub = rx_data;
                    end
                    if (state_r.idx == OFS_FLAGS_HI || state_r.idx == OFS_FLAGS_LO) begin
                        state_nxt.flags = {state_r.flags[7:0], rx_data};
                    end
                    if (state_r.idx >= OFS_LEN_HI && state_r.idx <= OFS_LEN_LO) begin
                        state_nxt.len = {state_r.len[23:0], rx_data};
                    end
                    if (state_r.idx >= OFS_PCRC_HI && state_r.idx <= OFS_PCRC_LO) begin
                        state_nxt.pcrc = {state_r.pcrc[23:0], rx_data};
                    end
                    if (state_r.idx == OFS_HCRC_HI) begin
                        state_nxt.hcrc_hi = rx_data;
                    end
                    if (state_r.idx == HDR_LAST) begin
                        state_nxt.idx = OFS_SYNC_HI;
                        state_nxt.len_cnt = state_r.len;
                        state_nxt.crc32 = CRC32_INIT;
                        if (!hdr_crc_ok) begin
                            state_nxt.status = STAT_HDR_CRC;
                            go_rsp = 1'b1;
                        end else begin
                            if (state_r.ver_bad) begin
                                state_nxt.status = STAT_BAD_VER;
                            end else if (!cmd_known) begin
                                state_nxt.status = STAT_BAD_CMD;
                            end else begin
                                state_nxt.status = STAT_OK;
                                state_nxt.req_valid = 1'b1;
                            end
                            if (state_r.len == 32'h00000000) begin
                                if (state_nxt.status == STAT_OK) begin
                                    // Fresh status, not the one left by the last frame
                                    state_nxt.status = pl_check(CRC32_INIT, state_nxt);
                                end
                                go_rsp = 1'b1;
                            end else begin
                                state_nxt.st = S_PL;
                            end
                        end
                    end
                end
            end
            S_PL: begin
                if (rx_fire) begin
                    state_nxt.pl_valid = 1'b1;
                    state_nxt.pl_data = rx_data;
                    state_nxt.crc32 = crc32_rx;
                    state_nxt.len_cnt = state_r.len_cnt - 32'h00000001;
                    if (state_r.len_cnt == 32'h00000001) begin
                        state_nxt.status = pl_check(crc32_rx, state_r);
                        go_rsp = 1'b1;
                    end
                end
            end
            S_RSP: begin
                if (tx_fire) begin
                    if (state_r.idx == HDR_LAST) begin
                        // Nothing follows the response header
                        state_nxt.tx_valid = 1'b0;
                        state_nxt.done = 1'b1;
                        state_nxt.st = S_HDR;
                        state_nxt.rx_ready = 1'b1;
                        state_nxt.idx = OFS_SYNC_HI;
                    end else begin
                        state_nxt.idx = nidx;
                        state_nxt.tx_data = tx_next;
                        if (nidx >= CRC_FIRST && nidx <= CRC_LAST) begin
                            state_nxt.tcrc = crc16_tx;
                        end
                    end
                end
            end
            default: begin
                state_nxt = REGS_RST;
            end
        endcase
        if (go_rsp) begin
            // Request side stalls while the response goes out
            state_nxt.st = S_RSP;
            state_nxt.rx_ready = 1'b0;
            state_nxt.idx = OFS_SYNC_HI;
            state_nxt.tcrc = CRC16_INIT;
            state_nxt.tx_valid = 1'b1;
            state_nxt.tx_data = SYNC_HI;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= REGS_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rx_ready = state_r.rx_ready;
    assign tx_valid = state_r.tx_valid;
    assign tx_data = state_r.tx_data;
    assign pl_valid = state_r.pl_valid;
    assign pl_data = state_r.pl_data;
    assign req_valid = state_r.req_valid;
    assign req_cmd = state_r.cmd;
    assign req_len = state_r.len;
    assign frame_done = state_r.done;
    assign frame_status = state_r.status;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_hdr_end;
        rx_fire && state_r.st == S_HDR && state_r.idx == HDR_LAST;
    endsequence

    sequence s_rsp_open;
        state_r.st == S_RSP && state_r.tx_valid && state_r.tx_data == SYNC_HI;
    endsequence

    property p_rsp_sync;
        $rose(state_r.tx_valid) |-> s_rsp_open ##0 state_r.idx == OFS_SYNC_HI;
    endproperty
    a_rsp_sync: assert property (p_rsp_sync) else $error("response not opened by sync");

    property p_rx_resync;
        rx_fire && state_r.st == S_HDR && state_r.idx == OFS_SYNC_HI && rx_data != SYNC_HI
            |=> state_r.idx == OFS_SYNC_HI && state_r.st == S_HDR;
    endproperty
    a_rx_resync: assert property (p_rx_resync) else $error("non-sync byte advanced header");

    property p_rsp_rev;
        tx_fire && state_r.idx == OFS_SYNC_LO |=> state_r.tx_data == PROTO_REV;
    endproperty
    a_rsp_rev: assert property (p_rsp_rev) else $error("wrong protocol version sent");

    property p_echo;
        tx_fire && state_r.idx == OFS_VER |=> state_r.tx_data == state_r.cmd
            ##1 (state_r.tx_data == state_r.sub || state_r.idx == OFS_CMD);
    endproperty
    a_echo: assert property (p_echo) else $error("command or sub-command not echoed");

    property p_rsp_zero;
        tx_fire && state_r.idx >= OFS_FLAGS_LO && state_r.idx < CRC_LAST
            |=> state_r.tx_data == 8'h00;
    endproperty
    a_rsp_zero: assert property (p_rsp_zero) else $error("nonzero length or checksum sent");

    property p_rsp_end;
        tx_fire && state_r.idx == HDR_LAST |=> !state_r.tx_valid && state_r.done
            ##1 (!state_r.tx_valid)[*2];
    endproperty
    a_rsp_end: assert property (p_rsp_end) else $error("bytes sent after response");

    property p_rsp_status;
        tx_fire && state_r.idx == OFS_SUB |=> state_r.tx_data == state_r.status;
    endproperty
    a_rsp_status: assert property (p_rsp_status) else $error("status byte not reported");

    property p_hdr_crc_bad;
        s_hdr_end ##0 !hdr_crc_ok |=> state_r.st == S_RSP && state_r.status == STAT_HDR_CRC;
    endproperty
    a_hdr_crc_bad: assert property (p_hdr_crc_bad) else $error("bad header checksum missed");

    property p_crc16_init;
        rx_fire && state_r.st == S_HDR && state_r.idx == OFS_SYNC_HI
            |=> state_r.crc16 == CRC16_INIT;
    endproperty
    a_crc16_init: assert property (p_crc16_init) else $error("header checksum not zeroed");

    property p_crc32_init;
        s_hdr_end |=> state_r.crc32 == CRC32_INIT;
    endproperty
    a_crc32_init: assert property (p_crc32_init) else $error("payload checksum seed wrong");

    property p_payload;
        s_hdr_end ##0 (hdr_crc_ok && state_r.len != 32'h00000000)
            |=> state_r.st == S_PL && state_r.len_cnt == $past(state_r.len);
    endproperty
    a_payload: assert property (p_payload) else $error("payload phase not entered");

    property p_pl_ignore;
        rx_fire && state_r.st == S_PL && state_r.len_cnt == 32'h00000001
            && state_r.flags[FLAG_NO_PCRC] && state_r.status == STAT_OK
            |=> state_r.status == STAT_OK && state_r.st == S_RSP;
    endproperty
    a_pl_ignore: assert property (p_pl_ignore) else $error("ignore flag not honoured");

    property p_flash_sub;
        s_hdr_end ##0 (state_r.cmd == CMD_FL_BOOT || state_r.cmd == CMD_FL_APP)
            |=> state_r.status != STAT_BAD_CMD;
    endproperty
    a_flash_sub: assert property (p_flash_sub) else $error("flash command refused");

    property p_msb_first;
        rx_fire && state_r.st == S_HDR && state_r.idx == OFS_LEN_LO
            |=> state_r.len[7:0] == $past(rx_data) && state_r.len[15:8] == $past(state_r.len[7:0]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("length not high byte first");
endmodule
`default_nettype wire

// ===== hw/cfrfh_pkg.sv
// Purpose: constants, state enum and register struct of the calibration read frame handler
// Assumes: one byte per handshake, header bytes in frame order
// Notes: status codes and the result table are local choices
// Operation
// - Command and response headers start with sync word 0xA1EC, marking a header.
// - Byte after the sync word is protocol version 0x03 in both directions.
// - Any payload follows the header as plain bytes from frame offset 0x40.
// - Header checksum at 0x3E covers the 60 bytes 0x02 through 0x3D.
// - Header checksum is a CRC, polynomial 0x1021, starting from zero.
// - Payload checksum at 0x3A is CRC 0x04C11DB7 starting at 0xFFFFFFF.
// - Flag bit 0 set skips payload check; host keeps it zero.
// - Response echoes the command byte and sub-command byte unchanged.
// - Response length and payload checksum are zero; no data follows it.
// - Flash-update requests disregard the sub-command byte whatever its value.
package cfrfh_pkg;
    localparam logic [7:0] SYNC_HI = 8'hA1;
    localparam logic [7:0] SYNC_LO = 8'hEC;
    localparam logic [7:0] PROTO_REV = 8'h03;
    localparam logic [7:0] CMD_RD_DEPTH = 8'h8D;
    localparam logic [7:0] CMD_RD_COLOUR = 8'h8E;
    localparam logic [7:0] CMD_RD_EXTR = 8'h8F;
    localparam logic [7:0] CMD_FL_BOOT = 8'h0B;
    localparam logic [7:0] CMD_FL_APP = 8'h0C;
    localparam logic [5:0] OFS_SYNC_HI = 6'h00;
    localparam logic [5:0] OFS_SYNC_LO = 6'h01;
    localparam logic [5:0] OFS_VER = 6'h02;
    localparam logic [5:0] OFS_CMD = 6'h03;
    localparam logic [5:0] OFS_SUB = 6'h04;
    localparam logic [5:0] OFS_STAT = 6'h05;
    localparam logic [5:0] OFS_FLAGS_HI = 6'h06;
    localparam logic [5:0] OFS_FLAGS_LO = 6'h07;
    localparam logic [5:0] OFS_LEN_HI = 6'h08;
    localparam logic [5:0] OFS_LEN_LO = 6'h0B;
    localparam logic [5:0] OFS_PCRC_HI = 6'h3A;
    localparam logic [5:0] OFS_PCRC_LO = 6'h3D;
    localparam logic [5:0] OFS_HCRC_HI = 6'h3E;
    localparam logic [5:0] HDR_LAST = 6'h3F;
    localparam logic [5:0] CRC_FIRST = 6'h02;
    localparam logic [5:0] CRC_LAST = 6'h3D;
    localparam logic [6:0] PAYLOAD_OFS = 7'h40;
    localparam int FLAG_NO_PCRC = 0;
    localparam logic [15:0] CRC16_POLY = 16'h1021;
    localparam logic [15:0] CRC16_INIT = 16'h0000;
    localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC32_INIT = 32'h0FFFFFFF;
    localparam logic [7:0] STAT_OK = 8'h00;
    localparam logic [7:0] STAT_BAD_VER = 8'h01;
    localparam logic [7:0] STAT_BAD_CMD = 8'h02;
    localparam logic [7:0] STAT_HDR_CRC = 8'h03;
    localparam logic [7:0] STAT_PL_CRC = 8'h04;

    typedef enum logic [1:0] {
        S_HDR = 2'b00,
        S_PL = 2'b01,
        S_RSP = 2'b10
    } cfrfh_state_e;

    typedef struct packed {
        cfrfh_state_e st;
        logic [5:0] idx;
        logic [31:0] len_cnt;
        logic [7:0] cmd;
        logic [7:0] sub;
        logic [15:0] flags;
        logic [31:0] len;
        logic [31:0] pcrc;
        logic [7:0] hcrc_hi;
        logic ver_bad;
        logic [15:0] crc16;
        logic [15:0] tcrc;
        logic [31:0] crc32;
        logic [7:0] status;
        logic rx_ready;
        logic tx_valid;
        logic [7:0] tx_data;
        logic pl_valid;
        logic [7:0] pl_data;
        logic req_valid;
        logic done;
    } cfrfh_regs_s;

    localparam cfrfh_regs_s REGS_RST = '{st: S_HDR, rx_ready: 1'b1, default: '0};
endpackage

// ===== tb/cfrfh_host_model.sv
// Purpose: remote host on the control link of the frame handler
// Assumes: request bytes change on the falling edge only
// Notes: a released data line shows the inverse of its last byte
`timescale 1ns/1ps
`default_nettype none
module cfrfh_host_model (
    input wire logic sys_clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    input wire logic stall
);
    logic [7:0] rsp_q[$];

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end

    // Sink may stall at will; the handler must hold each byte
    assign tx_ready = ~stall;

    // Whole frame in order, each byte held until taken
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(negedge sys_clk);
            rx_valid = 1'b1;
            rx_data = b[i];
            do @(posedge sys_clk); while (rx_ready !== 1'b1);
        end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask

    always @(posedge sys_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            rsp_q.push_back(tx_data);
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench of the calibration read frame handler
// Assumes: host model drives request bytes on the falling edge
// Notes: response and payload are rebuilt by bench functions
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, a); end end
module testbench
    import cfrfh_pkg::*;
;
    logic sys_clk;
    logic rst_n;
    logic rx_valid, rx_ready, tx_valid, tx_ready, pl_valid, req_valid, frame_done;
    logic slow, stall;
    logic [7:0] rx_data, tx_data, pl_data, req_cmd, frame_status;
    logic [31:0] req_len;
    int fails = 0;
    int n_tests = 0;
    int n_req = 0;
    logic [7:0] seed = 8'h23;
    logic [7:0] pl_q[$];
    logic [7:0] cmds[6] = '{8'h8D, 8'h8E, 8'h8F, 8'h0B, 8'h0C, 8'h55};

    cfrfh_frame_handler dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .pl_valid(pl_valid), .pl_data(pl_data), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_len(req_len), .frame_done(frame_done),
        .frame_status(frame_status));

    cfrfh_host_model host_u (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .stall(stall));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int j = 0; j < 8; j++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        return c;
    endfunction

    function automatic logic [31:0] c32(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {d, 24'h000000};
        for (int j = 0; j < 8; j++) c = c[31] ? ((c << 1) ^ 32'h04C11DB7) : (c << 1);
        return c;
    endfunction

    initial stall = 1'b0;
    always @(negedge sys_clk) stall = slow && (rnd() < 8'h60);

    always @(posedge sys_clk) begin
        if (pl_valid === 1'b1) pl_q.push_back(pl_data);
        if (req_valid === 1'b1) n_req++;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic run_frame(input logic [7:0] cmd, input logic [7:0] ver,
        input logic [15:0] flags, input int len, input bit bad_h, input bit bad_p,
        input bit junk);
        logic [7:0] h[64];
        logic [7:0] r[64];
        logic [7:0] pl[$];
        logic [7:0] f[$];
        logic [15:0] hc;
        logic [31:0] pc;
        logic [7:0] st;
        logic known;
        logic good;
        int k;
        int n0;
        pc = 32'h0FFFFFFF;
        for (int i = 0; i < len; i++) begin
            pl.push_back(rnd());
            pc = c32(pc, pl[i]);
        end
        // Sub, status and spare bytes stay random: the handler must not care
        for (int i = 0; i < 64; i++) h[i] = rnd();
        h[0] = 8'hA1;
        h[1] = 8'hEC;
        h[2] = ver;
        h[3] = cmd;
        {h[6], h[7]} = flags;
        {h[8], h[9], h[10], h[11]} = len;
        {h[58], h[59], h[60], h[61]} = pc ^ {31'h0, bad_p};
        hc = 16'h0000;
        for (int i = 2; i < 62; i++) hc = c16(hc, h[i]);
        {h[62], h[63]} = hc ^ {15'h0, bad_h};
        if (junk) f = '{8'h55, 8'hA1, 8'h00, 8'hA1};
        foreach (h[i]) f.push_back(h[i]);
        if (!bad_h) foreach (pl[i]) f.push_back(pl[i]);
        known = cmd inside {8'h8D, 8'h8E, 8'h8F, 8'h0B, 8'h0C};
        st = bad_h ? STAT_HDR_CRC : (ver !== 8'h03) ? STAT_BAD_VER : !known ? STAT_BAD_CMD :
            (bad_p && !flags[0]) ? STAT_PL_CRC : STAT_OK;
        for (int i = 0; i < 64; i++) r[i] = 8'h00;
        r[0] = 8'hA1;
        r[1] = 8'hEC;
        r[2] = 8'h03;
        r[3] = cmd;
        r[4] = h[4];
        r[5] = st;
        r[6] = h[6];
        r[7] = h[7];
        hc = 16'h0000;
        for (int i = 2; i < 62; i++) hc = c16(hc, r[i]);
        {r[62], r[63]} = hc;
        pl_q.delete();
        host_u.rsp_q.delete();
        n0 = n_req;
        host_u.send(f);
        k = 0;
        while (frame_done !== 1'b1 && k < 1000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        `CHK("frame_done", 1'b1, frame_done)
        `CHK("frame_status", st, frame_status)
        `CHK("rsp_count", 64, host_u.rsp_q.size())
        for (int i = 0; i < 64; i++) `CHK("rsp_byte", r[i], host_u.rsp_q[i])
        `CHK("pl_count", bad_h ? 0 : len, pl_q.size())
        for (int i = 0; i < pl_q.size(); i++) `CHK("pl_byte", pl[i], pl_q[i])
        good = !bad_h && ver === 8'h03 && known;
        `CHK("req_pulses", good ? 1 : 0, n_req - n0)
        if (good) begin
            `CHK("req_cmd", cmd, req_cmd)
            `CHK("req_len", len, req_len)
        end
    endtask

    initial begin
        rst_n = 1'b0;
        slow = 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        `CHK("rx_ready_rst", 1'b1, rx_ready)
        `CHK("tx_valid_rst", 1'b0, tx_valid)
        for (int i = 0; i < 6; i++) begin
            slow = i[0];
            run_frame(cmds[i], 8'h03, 16'h0000, i, 0, 0, 0);
        end
        run_frame(8'h8E, 8'h03, 16'h0000, 4, 1, 0, 0);
        run_frame(8'h8F, 8'h02, 16'h0000, 3, 0, 0, 0);
        run_frame(8'h0B, 8'h03, 16'h0000, 5, 0, 1, 0);
        // Empty payload right after a failed frame: status must not linger
        run_frame(8'h8E, 8'h03, 16'h0000, 0, 0, 0, 0);
        run_frame(8'h0C, 8'h03, 16'h0001, 5, 0, 1, 0);
        run_frame(8'h8D, 8'h03, 16'h0000, 2, 0, 0, 1);
        repeat (10) begin
            slow = rnd() > 8'h80;
            run_frame(cmds[rnd() % 5], 8'h03, {rnd(), rnd() & 8'hFE}, rnd() % 8, 0, 0, 0);
        end
        tally_and_finish();
    end

    // About twenty frames need roughly a sixth of this span, stalls included
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
